// *** core/audio_post_pkg.sv ***
// Constants, modes and carrier types of the audio post-processing chain.
package audio_post_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_LEVEL = 4'h0;
	localparam logic [3:0] ADDR_FORMAT = 4'h3;
	localparam logic [3:0] ADDR_PINSEL = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_PEAK = 4'h9;
	localparam logic [3:0] ADDR_QREAD = 4'ha;
	// ----------------------------------------
	// Field layouts and reset values
	// ----------------------------------------
	localparam int LEVEL_CMD_LSB = 0;
	localparam int FADE_DIR_BIT = 2;
	localparam int FORMAT_LSB = 0;
	localparam int PINSEL_DEEMPH_BIT = 0;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [3:0] FORMAT_RESET = 4'he;
	localparam logic [3:0] FMT_ROM_I2S = 4'ha;
	localparam logic [3:0] FMT_ROM_EIAJ = 4'hb;
	localparam logic [3:0] FMT_4FS_A = 4'h0;
	localparam logic [3:0] FMT_4FS_B = 4'h4;
	localparam logic [3:0] FMT_4FS_C = 4'hc;
	localparam logic [3:0] FMT_2FS_A = 4'h3;
	localparam logic [3:0] FMT_2FS_B = 4'h7;
	localparam logic [3:0] FMT_2FS_C = 4'hf;
	// ----------------------------------------
	// Gain and timing
	// ----------------------------------------
	localparam logic [7:0] GAIN_UNITY = 8'h80;
	localparam logic [7:0] GAIN_OVERSAMPLE = 8'h78;
	localparam logic [7:0] GAIN_ATTEN = 8'h20;
	localparam logic [7:0] GAIN_SILENT = 8'h00;
	localparam int CLK_HZ = 20000000;
	localparam int MUTE_TIME_US = 3000;
	localparam int MUTE_STEPS = 128;
	localparam int STEP_CYCLES = (CLK_HZ / 1000000) * MUTE_TIME_US / MUTE_STEPS;
	localparam logic [2:0] CMD_FULL = 3'h0;
	localparam logic [2:0] CMD_MUTE = 3'h1;
	localparam logic [2:0] CMD_ATTEN = 3'h2;
	localparam logic [2:0] CMD_FADE = 3'h3;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
		logic err_left;
		logic err_right;
	} sample_t;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} stereo_t;
endpackage

// *** core/sample_fifo.sv ***
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	wire push = wr_valid_in && wr_ready_out;
	wire pop = rd_valid_out && rd_ready_in;
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign wr_ready_out = ready_q;
	assign rd_valid_out = cnt_q != '0;
	assign rd_data_out = mem_q[rp_q];
	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			mem_q[wp_q] <= wr_data_in;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_d;
			ready_q <= cnt_d != (AW+1)'(DEPTH);
		end
	end
endmodule // sample_fifo

// *** core/cd_audio_post_processor.sv ***
// Audio post-processing chain: filter, concealment, level control and peak detector.
// Overview of operation
// - Insert de-emphasis section when subcode signals pre-emphasis.
// - Without de-emphasis, use phase compensation section instead.
// - De-emphasis routed to pin five bypasses the internal section.
// - Interpolation filter raises sample rate by two or four.
// - Four-times response keeps flat passband and stopband rejection.
// - Oversampling in use scales full-scale and fade-up gain down by half a decibel.
// - Single bad sample becomes midpoint of its neighbours.
// - Left and right channels are concealed independently.
// - Bad runs hold last good value, then interpolate one sample.
// - No concealment in CD-ROM output formats.
// - Host selects mute, attenuation, full-scale or fade by register.
// - Soft mute reaches zero in at most 128 steps over 3 ms.
// - Attenuation applies a fixed gain of minus twelve decibels.
// - Full-scale ramps gain back to unity, 3 ms from mute.
// - Fade uses 128-stage counter, 0.07 dB per stage.
// - Largest absolute positive peak kept per channel.
// - Top eight peak bits replace CRC in Q-channel word.
// - Peaks clear after host reads the Q-channel data.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cd_audio_post_processor #(
	parameter int FIFO_DEPTH = 32,
	parameter int STEP_CYCLES = audio_post_pkg::STEP_CYCLES
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire audio_post_pkg::sample_t smp_in,
	input wire logic smp_valid_in,
	output logic smp_ready_out,
	input wire logic pre_emphasis_in,
	input wire logic [95:0] q_word_in,
	output logic [95:0] q_word_out,
	output logic versatile_output_pin_five_out,
	output audio_post_pkg::stereo_t aud_out,
	output logic aud_valid_out,
	input wire logic aud_ready_in
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] level_q;
	logic [3:0] format_q;
	logic pinsel_q;
	logic [7:0] rdata_q;
	wire wr_level = reg_wr_in && reg_addr_in == audio_post_pkg::ADDR_LEVEL;
	wire wr_format = reg_wr_in && reg_addr_in == audio_post_pkg::ADDR_FORMAT;
	wire wr_pinsel = reg_wr_in && reg_addr_in == audio_post_pkg::ADDR_PINSEL;
	wire q_read = reg_rd_in && reg_addr_in == audio_post_pkg::ADDR_QREAD;
	wire [2:0] level_cmd = {1'b0, level_q[audio_post_pkg::LEVEL_CMD_LSB +: 2]};
	wire fade_up = level_q[audio_post_pkg::FADE_DIR_BIT];
	wire rom_mode = format_q == audio_post_pkg::FMT_ROM_I2S || format_q == audio_post_pkg::FMT_ROM_EIAJ;
	wire os4 = format_q == audio_post_pkg::FMT_4FS_A || format_q == audio_post_pkg::FMT_4FS_B
		|| format_q == audio_post_pkg::FMT_4FS_C;
	wire os2 = format_q == audio_post_pkg::FMT_2FS_A || format_q == audio_post_pkg::FMT_2FS_B
		|| format_q == audio_post_pkg::FMT_2FS_C;
	wire oversample = os4 || os2;
	wire deemph_on = pre_emphasis_in && !pinsel_q;
	logic [7:0] gain_q;
	logic [7:0] peak_l_q;
	logic [7:0] peak_r_q;
	wire [7:0] status = {4'h0, os4, os2, deemph_on, gain_q == audio_post_pkg::GAIN_SILENT};
	wire [7:0] rd_mux = (reg_addr_in == audio_post_pkg::ADDR_LEVEL) ? level_q :
		(reg_addr_in == audio_post_pkg::ADDR_FORMAT) ? {4'h0, format_q} :
		(reg_addr_in == audio_post_pkg::ADDR_PINSEL) ? {7'h00, pinsel_q} :
		(reg_addr_in == audio_post_pkg::ADDR_STATUS) ? status :
		(reg_addr_in == audio_post_pkg::ADDR_PEAK) ? peak_l_q : 8'h00;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			level_q <= audio_post_pkg::LEVEL_RESET;
			format_q <= audio_post_pkg::FORMAT_RESET;
			pinsel_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			if (wr_level) begin
				level_q <= reg_wdata_in;
			end
			if (wr_format) begin
				format_q <= reg_wdata_in[audio_post_pkg::FORMAT_LSB +: 4];
			end
			if (wr_pinsel) begin
				pinsel_q <= reg_wdata_in[audio_post_pkg::PINSEL_DEEMPH_BIT];
			end
			rdata_q <= reg_rd_in ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata_out = rdata_q;
	// ----------------------------------------
	// Input buffer
	// ----------------------------------------
	audio_post_pkg::sample_t fifo_data;
	logic fifo_valid;
	logic stage_ready;
	sample_fifo #(.WIDTH($bits(audio_post_pkg::sample_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.wr_data_in(smp_in),
		.wr_valid_in(smp_valid_in),
		.wr_ready_out(smp_ready_out),
		.rd_data_out(fifo_data),
		.rd_valid_out(fifo_valid),
		.rd_ready_in(stage_ready)
	);
	// ----------------------------------------
	// Concealment, one sample of look-ahead
	// ----------------------------------------
	logic [15:0] cur_q [2];
	logic cur_err_q [2];
	logic cur_vld_q;
	logic [15:0] good_q [2];
	logic [15:0] conc [2];
	wire [15:0] nxt [2] = '{fifo_data.left, fifo_data.right};
	wire nxt_err [2] = '{fifo_data.err_left, fifo_data.err_right};
	wire take = fifo_valid && stage_ready;
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_conc
			wire [16:0] mid_sum = {good_q[ch][15], good_q[ch]} + {nxt[ch][15], nxt[ch]};
			assign conc[ch] = (rom_mode || !cur_err_q[ch]) ? cur_q[ch] :
				(!nxt_err[ch]) ? mid_sum[16:1] : good_q[ch];
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					cur_q[ch] <= 16'h0000;
					cur_err_q[ch] <= 1'b0;
					good_q[ch] <= 16'h0000;
				end else if (take) begin
					cur_q[ch] <= nxt[ch];
					cur_err_q[ch] <= nxt_err[ch];
					if (cur_vld_q && (!cur_err_q[ch] || rom_mode)) begin
						good_q[ch] <= cur_q[ch];
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cur_vld_q <= 1'b0;
		end else if (take) begin
			cur_vld_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Filter sections and oversampling
	// ----------------------------------------
	logic [15:0] flt_q [2];
	logic [15:0] os_q [2];
	logic [1:0] rep_q;
	logic busy_q;
	wire [1:0] rep_max = os4 ? 2'd3 : (os2 ? 2'd1 : 2'd0);
	logic out_vld_q;
	wire out_free = !out_vld_q || aud_ready_in;
	assign stage_ready = !busy_q && out_free;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_flt
			wire signed [17:0] x = {{2{conc[ch][15]}}, conc[ch]};
			wire signed [17:0] y = {{2{flt_q[ch][15]}}, flt_q[ch]};
			wire signed [17:0] de = y + ((x - y) >>> 1);
			wire signed [17:0] ph = x - ((x - y) >>> 4);
			wire signed [17:0] sel = deemph_on ? de : ph;
			wire signed [17:0] o = {{2{os_q[ch][15]}}, os_q[ch]};
			wire signed [17:0] t = {{2{flt_q[ch][15]}}, flt_q[ch]};
			wire signed [17:0] osn = o + ((t - o) >>> 1);
			always_ff @(posedge sys_clk_in) begin
				if (rst_in) begin
					flt_q[ch] <= 16'h0000;
					os_q[ch] <= 16'h0000;
				end else begin
					if (take && cur_vld_q) begin
						flt_q[ch] <= sel[15:0];
					end
					if (busy_q && out_free) begin
						os_q[ch] <= oversample ? osn[15:0] : flt_q[ch];
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			rep_q <= 2'd0;
		end else if (take && cur_vld_q) begin
			busy_q <= 1'b1;
			rep_q <= rep_max;
		end else if (busy_q && out_free) begin
			busy_q <= rep_q != 2'd0;
			rep_q <= rep_q - 2'd1;
		end
	end
	// ----------------------------------------
	// Level control
	// ----------------------------------------
	logic [$clog2(STEP_CYCLES+1)-1:0] div_q;
	wire step = div_q == '0;
	wire [7:0] unity = oversample ? audio_post_pkg::GAIN_OVERSAMPLE : audio_post_pkg::GAIN_UNITY;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			div_q <= '0;
			gain_q <= audio_post_pkg::GAIN_UNITY;
		end else begin
			div_q <= step ? ($clog2(STEP_CYCLES+1))'(STEP_CYCLES-1) : div_q - 1'b1;
			if (step) begin
				unique case (level_cmd)
					audio_post_pkg::CMD_MUTE: gain_q <= (gain_q == 8'h00) ? 8'h00 : gain_q - 8'h01;
					audio_post_pkg::CMD_ATTEN: gain_q <= audio_post_pkg::GAIN_ATTEN;
					audio_post_pkg::CMD_FADE: begin
						if (fade_up) begin
							gain_q <= (gain_q >= unity) ? unity : gain_q + 8'h01;
						end else begin
							gain_q <= (gain_q == 8'h00) ? 8'h00 : gain_q - 8'h01;
						end
					end
					default: gain_q <= (gain_q >= unity) ? unity : gain_q + 8'h01;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Output stage and peak detector
	// ----------------------------------------
	logic [15:0] scaled [2];
	generate
		for (ch = 0; ch < 2; ch++) begin : g_out
			wire signed [24:0] prod = $signed(os_q[ch]) * $signed({1'b0, gain_q});
			assign scaled[ch] = prod[22:7];
		end
	endgenerate
	audio_post_pkg::stereo_t aud_q;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			aud_q <= '0;
			out_vld_q <= 1'b0;
		end else if (out_free) begin
			out_vld_q <= busy_q;
			aud_q <= '{left: scaled[0], right: scaled[1]};
		end
	end
	assign aud_out = aud_q;
	assign aud_valid_out = out_vld_q;
	wire [7:0] pk_l = aud_q.left[14:7];
	wire [7:0] pk_r = aud_q.right[14:7];
	wire hit_l = out_vld_q && !aud_q.left[15] && pk_l > peak_l_q;
	wire hit_r = out_vld_q && !aud_q.right[15] && pk_r > peak_r_q;
	logic [95:0] q_q;
	logic pin5_q;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			peak_l_q <= 8'h00;
			peak_r_q <= 8'h00;
			q_q <= '0;
			pin5_q <= 1'b0;
		end else begin
			peak_l_q <= hit_l ? pk_l : (q_read ? 8'h00 : peak_l_q);
			peak_r_q <= hit_r ? pk_r : (q_read ? 8'h00 : peak_r_q);
			q_q <= {peak_r_q, peak_l_q, q_word_in[79:0]};
			pin5_q <= pinsel_q && pre_emphasis_in;
		end
	end
	assign q_word_out = q_q;
	assign versatile_output_pin_five_out = pin5_q;
endmodule // cd_audio_post_processor

// *** testbench/audio_post_asserts.sv ***
// Port-level checks of the audio post-processor.
`timescale 1ns/1ps
module audio_post_asserts (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic smp_valid_in,
	input wire logic pre_emphasis_in,
	input wire logic [95:0] q_word_in,
	input wire logic [95:0] q_word_out,
	input wire logic versatile_output_pin_five_out,
	input wire audio_post_pkg::stereo_t aud_out,
	input wire logic aud_valid_out,
	input wire logic aud_ready_in
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	wire logic rd_stat = reg_rd_in && reg_addr_in == 4'h8;
	sequence s_quiet;
		(!smp_valid_in && !aud_valid_out)[*8];
	endsequence
	sequence s_pre;
		(pre_emphasis_in && !versatile_output_pin_five_out)[*3];
	endsequence
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_unmapped;
		reg_rd_in && !(reg_addr_in inside {4'h0, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha}) |=> reg_rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		aud_valid_out && !aud_ready_in |=> aud_valid_out && $stable(aud_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output word dropped");
	property p_pin5;
		versatile_output_pin_five_out |-> $past(pre_emphasis_in);
	endproperty
	a_pin5: assert property (p_pin5) else $error("pin five without emphasis");
	property p_deemph;
		s_pre ##0 rd_stat ##1 !versatile_output_pin_five_out |-> reg_rdata_out[1];
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis not inserted");
	property p_bypass;
		versatile_output_pin_five_out[*3] ##0 rd_stat ##1 versatile_output_pin_five_out |-> !reg_rdata_out[1];
	endproperty
	a_bypass: assert property (p_bypass) else $error("de-emphasis not bypassed");
	property p_qpass;
		!$past(rst_in) |-> q_word_out[79:0] == $past(q_word_in[79:0]);
	endproperty
	a_qpass: assert property (p_qpass) else $error("subcode bits altered");
	property p_clear;
		s_quiet ##0 (reg_rd_in && reg_addr_in == 4'ha) |-> ##2 q_word_out[95:80] == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("peaks not cleared");
endmodule // audio_post_asserts
bind cd_audio_post_processor audio_post_asserts chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.smp_valid_in(smp_valid_in), .pre_emphasis_in(pre_emphasis_in), .q_word_in(q_word_in),
	.q_word_out(q_word_out), .versatile_output_pin_five_out(versatile_output_pin_five_out),
	.aud_out(aud_out), .aud_valid_out(aud_valid_out), .aud_ready_in(aud_ready_in));

// *** testbench/audio_sink_model.sv ***
// Converter-side partner that stalls one cycle in four and records words.
`timescale 1ns/1ps
module audio_sink_model (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire audio_post_pkg::stereo_t aud_in,
	input wire logic aud_valid_in,
	output logic aud_ready_out,
	input wire logic clear_in,
	output logic [15:0] max_left_out,
	output logic [15:0] last_left_out,
	output int words_out
);
	logic [1:0] phase_q;
	assign aud_ready_out = phase_q != 2'h3;
	always_ff @(posedge sys_clk_in) begin
		phase_q <= rst_in ? 2'h0 : phase_q + 2'h1;
		if (rst_in || clear_in) begin
			max_left_out <= 16'h0000;
			last_left_out <= 16'h0000;
			words_out <= 0;
		end else if (aud_valid_in && aud_ready_out) begin
			words_out <= words_out + 1;
			last_left_out <= aud_in.left;
			if (aud_in.left > max_left_out)
				max_left_out <= aud_in.left;
		end
	end
endmodule // audio_sink_model

// *** testbench/tb.sv ***
// Self-checking bench of the audio post-processor.
`timescale 1ns/1ps
module tb;
	logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, smp_valid_in, pre_emphasis_in, clear;
	logic smp_ready_out, aud_valid_out, aud_ready_in, pin5;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, d;
	logic [95:0] q_word_out;
	logic [15:0] max_left, last_left, lv;
	audio_post_pkg::sample_t smp_in;
	audio_post_pkg::stereo_t aud_out;
	int words, n_fail, comparisons, k;
	logic [3:0] fmt [6] = '{4'h0, 4'h4, 4'hc, 4'h3, 4'h7, 4'hf};
	logic [7:0] cmd [5] = '{8'h02, 8'h01, 8'h00, 8'h03, 8'h07};
	logic [15:0] lvl [5] = '{16'h0400, 16'h0000, 16'h1000, 16'h0000, 16'h1000};
	cd_audio_post_processor #(.STEP_CYCLES(2)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .smp_in(smp_in), .smp_valid_in(smp_valid_in), .smp_ready_out(smp_ready_out),
		.pre_emphasis_in(pre_emphasis_in), .q_word_in({16'h0000, 80'h5aa55aa55aa55aa55aa5}),
		.q_word_out(q_word_out), .versatile_output_pin_five_out(pin5), .aud_out(aud_out),
		.aud_valid_out(aud_valid_out), .aud_ready_in(aud_ready_in));
	audio_sink_model sink (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .aud_in(aud_out), .aud_valid_in(aud_valid_out),
		.aud_ready_out(aud_ready_in), .clear_in(clear), .max_left_out(max_left), .last_left_out(last_left),
		.words_out(words));
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	task automatic finish_test();
		$display("counts: %0d compared, %0d wrong", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] lo, hi, got);
		comparisons++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			n_fail++;
			$display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		@(posedge sys_clk_in);
		v = reg_rdata_out;
	endtask
	task automatic stream(input logic el, er, input int run);
		int i, q;
		logic b;
		clear <= 1'b1;
		@(posedge sys_clk_in);
		clear <= 1'b0;
		smp_valid_in <= 1'b1;
		for (i = 0; i < 16; i++) begin
			b = i >= 10 && i < 10 + run;
			smp_in <= '{b ? 16'h7000 : 16'h1000, 16'h1000, b && el, b && er};
			for (q = 0; q < 500 && smp_ready_out !== 1'b1; q++)
				@(posedge sys_clk_in);
			if (q >= 500) begin
				check("sample ready", 16'h0001, 16'h0001, {15'h0000, smp_ready_out});
				finish_test();
			end
			@(posedge sys_clk_in);
		end
		smp_valid_in <= 1'b0;
		q = 0;
		for (i = 0; i < 3000 && q < 16; i++) begin
			@(posedge sys_clk_in);
			q = (aud_valid_out === 1'b0) ? q + 1 : 0;
		end
		check("stream drained", 16'h0010, 16'h0010, q[15:0]);
		if (q < 16)
			finish_test();
	endtask
	initial begin
		{rst_in, reg_wr_in, reg_rd_in, smp_valid_in, pre_emphasis_in, clear} = 6'b100000;
		{reg_addr_in, reg_wdata_in, smp_in} = '0;
		repeat (12) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		@(posedge sys_clk_in);
		rd(4'h8, d);
		check("reset status", 16'h0100, 16'h0100, {7'h00, smp_ready_out, d});
		rd(4'h5, d);
		check("unmapped read", 16'h0000, 16'h0000, {8'h00, d});
		$display("test reset done");
		stream(1'b1, 1'b0, 1);
		check("single conceal", 16'h0000, 16'h17ff, max_left);
		stream(1'b1, 1'b0, 3);
		check("run conceal", 16'h0000, 16'h17ff, max_left);
		stream(1'b0, 1'b1, 1);
		check("channel split", 16'h2000, 16'h7fff, max_left);
		wr(4'h3, 8'h0a);
		stream(1'b1, 1'b0, 1);
		check("data format", 16'h2000, 16'h7fff, max_left);
		$display("test conceal done");
		rd(4'h9, d);
		check("left peak", 16'h001e, 16'h00ff, {8'h00, d});
		check("q left", 16'h00c0, 16'h00ff, {8'h00, q_word_out[87:80]});
		check("q right", 16'h001e, 16'h00ff, {8'h00, q_word_out[95:88]});
		rd(4'ha, d);
		rd(4'h9, d);
		check("peak clear", 16'h0000, 16'h0000, {d, q_word_out[95:88]});
		$display("test peak done");
		for (k = 0; k < 6; k++) begin
			wr(4'h3, {4'h0, fmt[k]});
			rd(4'h8, d);
			check("os status", k < 3 ? 16'h8 : 16'h4, k < 3 ? 16'h8 : 16'h4, {8'h00, d});
			stream(1'b0, 1'b0, 0);
			check("os words", k < 3 ? 16'd60 : 16'd30, k < 3 ? 16'd64 : 16'd32, words[15:0]);
			check("os level", 16'h0ec0, 16'h0f40, last_left);
		end
		wr(4'h3, 8'h0e);
		$display("test oversample done");
		for (k = 0; k < 5; k++) begin
			wr(4'h0, cmd[k]);
			repeat (600) @(posedge sys_clk_in);
			rd(4'h8, d);
			check("gain zero", {15'h0, lvl[k] == 16'h0}, {15'h0, lvl[k] == 16'h0}, {8'h00, d});
			stream(1'b0, 1'b0, 0);
			lv = lvl[k] > 16'h40 ? lvl[k] - 16'h40 : 16'h0;
			check("gain level", lv, lvl[k] + 16'h40, last_left);
		end
		$display("test level done");
		pre_emphasis_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rd(4'h8, d);
		check("de-emphasis", 16'h0002, 16'h0002, {8'h00, d});
		wr(4'h4, 8'h01);
		repeat (4) @(posedge sys_clk_in);
		rd(4'h8, d);
		check("pin five", 16'h0100, 16'h0100, {7'h00, pin5, d});
		$display("test emphasis done");
		finish_test();
	end
endmodule // tb
